/* File: verilog/msm_data_side.sv */
// Data-space access map: read and write address generators, memory, lanes and traps.
// Assumes the core issues at most one read and one write per cycle on the same clock.
`timescale 1ns/100ps
module msm_data_side
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Program side
	input msm_pkg::msm_pctl_t pctl,
	input wire logic [15:0] fetch_data,
	// Direct address forms
	input wire logic use_near,
	input wire logic [12:0] near_field,
	input wire logic use_full,
	input wire logic [15:0] full_field,
	// Read generator
	input msm_pkg::msm_dreq_t rd_req,
	// Write generator
	input msm_pkg::msm_dreq_t wr_req,
	// Special register view
	input wire logic [15:0] special_rdata,
	input wire logic [1023:0] special_impl,
	// Working registers
	input msm_pkg::msm_wop_t wop,
	input wire logic [3:0] wsel,
	input wire logic wbyte,
	input wire logic [3:0] wrsel,
	output logic [15:0] wrdata,
	// Answers
	output msm_pkg::msm_drsp_t rd_rsp,
	output logic [15:0] window_addr,
	output logic addr_error_trap,
	output logic [1:0] lane_we,
	output logic [23:0] prog_addr,
	output logic prog_rd,
	output logic table_denied,
	output logic [15:0] cfg_word0,
	output logic [15:0] cfg_word1,
	output logic cfg_done,
	output logic in_vector_table,
	output logic in_alt_vector_table
);
	import msm_pkg::*;

	typedef struct packed
	{
		msm_drsp_t rsp;
		logic [15:0] win;
		logic trap;
	} msm_dstate_t;

	msm_dstate_t s_ff;
	msm_dstate_t nxt_s;
	logic [15:0] ram [0:RAM_WORDS-1];
	logic [15:0] rd_ea;
	logic [15:0] rd_word;
	logic [15:0] rd_val;
	logic rd_mis;
	logic wr_mis;
	logic [1:0] wr_lanes;
	logic rd_impl;
	logic rd_special;

	msm_prog_side u_prog
	(
		.clock(clock),
		.nrst(nrst),
		.ctl(pctl),
		.fetch_data(fetch_data),
		.prog_addr(prog_addr),
		.prog_rd(prog_rd),
		.table_denied(table_denied),
		.cfg_word0(cfg_word0),
		.cfg_word1(cfg_word1),
		.cfg_done(cfg_done),
		.in_vector_table(in_vector_table),
		.in_alt_vector_table(in_alt_vector_table)
	);

	msm_wreg u_wreg
	(
		.clock(clock),
		.nrst(nrst),
		.op(wop),
		.sel(wsel),
		.byte_op(wbyte),
		.din(rd_rsp.data),
		.rsel(wrsel),
		.rdata(wrdata)
	);

	// Near direct form zero-extends 13 bits; the full form reaches all 64 Kbytes.
	always_comb
	begin
		rd_ea = rd_req.addr;
		if (use_near)
			rd_ea = msm_near_ea(near_field);
		else if (use_full)
			rd_ea = full_field;
	end

	// Each generator checks its own address.
	assign rd_mis = rd_req.valid & msm_misaligned(rd_req.word, rd_ea);
	assign wr_mis = wr_req.valid & msm_misaligned(wr_req.word, wr_req.addr);

	assign rd_special = (rd_ea <= DA_SPECIAL_TOP);
	assign rd_impl = !rd_ea[15] && (rd_ea <= DA_IMPL_TOP);
	assign rd_word = ram[rd_ea[12:1]];

	// Lane strobes share one word decode; a bad word write fires none.
	always_comb
	begin
		wr_lanes = 2'b00;
		if (wr_req.valid && !wr_req.addr[15] && wr_req.addr <= DA_IMPL_TOP
			&& wr_req.addr > DA_SPECIAL_TOP && !wr_mis)
		begin
			if (wr_req.word)
				wr_lanes = 2'b11;
			else
				wr_lanes = wr_req.addr[0] ? 2'b10 : 2'b01;
		end
	end
	assign lane_we = wr_lanes;

	always_ff @(posedge clock)
	begin
		// Byte data sits in the low lane of the request; odd lane is the high byte.
		if (wr_lanes[0])
			ram[wr_req.addr[12:1]][7:0] <= wr_req.data[7:0];
		if (wr_lanes[1])
			ram[wr_req.addr[12:1]][15:8] <= wr_req.word ? wr_req.data[15:8] : wr_req.data[7:0];
	end

	always_comb
	begin
		rd_val = 16'h0000;
		if (rd_impl && rd_special)
			rd_val = special_impl[rd_ea[10:1]] ? special_rdata : 16'h0000;
		else if (rd_impl)
			rd_val = rd_word;
		if (!rd_req.word)
			rd_val = msm_lane_pick(rd_ea[0], rd_val);
	end

	// A misaligned read still completes; the trap rises with its answer in the next cycle.
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.rsp.valid = rd_req.valid;
		nxt_s.rsp.window = rd_req.valid & rd_ea[15];
		nxt_s.rsp.data = rd_val;
		nxt_s.win = {1'b0, rd_ea[14:0]};
		nxt_s.trap = rd_mis | wr_mis;
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			s_ff.rsp <= '0;
			s_ff.win <= 16'h0000;
			s_ff.trap <= 1'b0;
		end
		else
			s_ff <= nxt_s;
	end

	assign rd_rsp = s_ff.rsp;
	assign window_addr = s_ff.win;
	assign addr_error_trap = s_ff.trap;

	sequence seq_bad_write;
		wr_req.valid && wr_req.word && wr_req.addr[0];
	endsequence
	sequence seq_trap_next;
		addr_error_trap;
	endsequence

	AST_MIS_WRITE: assert property (@(posedge clock) disable iff (!nrst)
		seq_bad_write |-> (lane_we == 2'b00) ##1 seq_trap_next) else $error("Bad write not held.");
	AST_MIS_READ: assert property (@(posedge clock) disable iff (!nrst)
		rd_mis |=> rd_rsp.valid && addr_error_trap) else $error("Bad read not completed.");
	AST_HIGH_ZERO: assert property (@(posedge clock) disable iff (!nrst)
		rd_req.valid && !rd_ea[15] && rd_ea > DA_IMPL_TOP |=> rd_rsp.data == 16'h0000)
		else $error("Unimplemented read not zero.");
	AST_BYTE_LOW: assert property (@(posedge clock) disable iff (!nrst)
		rd_req.valid && !rd_req.word |=> rd_rsp.data[15:8] == 8'h00) else $error("Byte not low.");
	AST_BYTE_LANE: assert property (@(posedge clock) disable iff (!nrst)
		wr_req.valid && !wr_req.word && wr_lanes != 2'b00 |-> wr_lanes == (wr_req.addr[0] ? 2'b10 : 2'b01))
		else $error("Wrong byte lane.");
	AST_WINDOW: assert property (@(posedge clock) disable iff (!nrst)
		rd_req.valid && rd_ea[15] |=> rd_rsp.window && rd_rsp.data == 16'h0000)
		else $error("Window not flagged.");
endmodule : msm_data_side

/* File: include/msm_pkg.sv */
// Constants and carrier types for the memory space access map.
// Assumes one core clock and a synchronous active-low reset shared by all users.
// Notes on behaviour
// - Program address 24 bits from 23-bit counter
// - User program access limited to lower half
// - Program location is lower and upper word
// - Counter word aligned, steps by two
// - Execution starts at zero, vector word follows
// - Primary and alternate interrupt vector tables
// - Top two words loaded as configuration
// - Linear data space, separate read/write generators
// - Data effective address is 16-bit byte pointer
// - Top address bit selects visibility window
// - Outside implemented memory reads return zero
// - Words stored little-endian
// - Post-increment adds one byte, two word
// - Byte read selects lane, lands low
// - Shared word decode, separate lane strobes
// - Odd word access raises address error trap
// - Misaligned write suppressed, read completes, trap
// - Byte load keeps register high byte
// - Sign extend and upper byte clear ops
// - Near space reached by 13-bit field
// - 16-bit direct field reaches whole space
// - Unimplemented special register addresses read zero
package msm_pkg;
	localparam int PA_W = 24;
	localparam int PC_W = 23;
	localparam int EA_W = 16;
	localparam logic [23:0] PA_RESET = 24'h000000;
	localparam logic [23:0] PA_RESET_TARGET = 24'h000002;
	localparam logic [23:0] PA_IVT_LO = 24'h000004;
	localparam logic [23:0] PA_IVT_HI = 24'h0000FF;
	localparam logic [23:0] PA_AIVT_LO = 24'h000100;
	localparam logic [23:0] PA_AIVT_HI = 24'h0001FF;
	localparam logic [23:0] PA_USER_HI = 24'h7FFFFF;
	localparam logic [23:0] PA_CFG_WORD1 = 24'h00ABFC;
	localparam logic [23:0] PA_CFG_WORD2 = 24'h00ABFE;
	localparam logic [7:0] TBLPAGE_CFG_BIT = 8'h80;
	localparam logic [15:0] DA_IMPL_TOP = 16'h1FFF;
	localparam logic [15:0] DA_SPECIAL_TOP = 16'h07FF;
	localparam logic [15:0] DA_NEAR_TOP = 16'h1FFF;
	localparam int RAM_WORDS = 4096;
	localparam int SPECIAL_WORDS = 1024;
	localparam int CFG_WORDS = 2;
	localparam logic [15:0] CFG_RESET = 16'hFFFF;
	localparam logic [15:0] WREG_RESET = 16'h0000;
	localparam logic [22:0] PC_RESET = 23'h000000;

	typedef enum logic [2:0]
	{
		MSM_OP_NONE = 3'b000,
		MSM_OP_LOAD = 3'b001,
		MSM_OP_SIGN = 3'b010,
		MSM_OP_CLEAR_HI = 3'b011,
		MSM_OP_INC = 3'b100
	} msm_wop_t;

	typedef enum logic [1:0]
	{
		MSM_FE_RESET = 2'b00,
		MSM_FE_CFG0 = 2'b01,
		MSM_FE_CFG1 = 2'b10,
		MSM_FE_RUN = 2'b11
	} msm_fstate_t;

	// One request of an address generator.
	typedef struct packed
	{
		logic valid;
		logic word;
		logic [15:0] addr;
		logic [15:0] data;
	} msm_dreq_t;

	// One answer of the read path.
	typedef struct packed
	{
		logic valid;
		logic window;
		logic [15:0] data;
	} msm_drsp_t;

	// Program-side control from the core.
	typedef struct packed
	{
		logic step;
		logic down;
		logic jump;
		logic [22:0] target;
		logic table_req;
		logic [7:0] table_page;
		logic [15:0] table_off;
	} msm_pctl_t;

	// Direct address forms from the instruction decoder.
	function automatic logic [15:0] msm_near_ea(input logic [12:0] field);
		msm_near_ea = {3'h0, field};
	endfunction : msm_near_ea

	function automatic logic msm_misaligned(input logic word, input logic [15:0] ea);
		msm_misaligned = word & ea[0];
	endfunction : msm_misaligned

	function automatic logic [15:0] msm_lane_pick(input logic hi, input logic [15:0] w);
		msm_lane_pick = hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
	endfunction : msm_lane_pick
endpackage : msm_pkg

/* File: verilog/msm_prog_side.sv */
// Program-space address generator, user/configuration gate and reset-time config load.
// Assumes the core presents control in the same clock domain and holds fetch data one cycle.
`timescale 1ns/100ps
module msm_prog_side
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Core control
	input msm_pkg::msm_pctl_t ctl,
	input wire logic [15:0] fetch_data,
	// Outputs
	output logic [23:0] prog_addr,
	output logic prog_rd,
	output logic table_denied,
	output logic [15:0] cfg_word0,
	output logic [15:0] cfg_word1,
	output logic cfg_done,
	output logic in_vector_table,
	output logic in_alt_vector_table
);
	import msm_pkg::*;

	typedef struct packed
	{
		msm_fstate_t st;
		logic [22:0] pc;
		logic [15:0] cfg0;
		logic [15:0] cfg1;
		logic denied;
	} msm_pstate_t;

	msm_pstate_t s_ff;
	msm_pstate_t nxt_s;
	logic [23:0] tbl_addr;
	logic tbl_ok;

	// Configuration space is reached only with the page top bit set.
	assign tbl_addr = {ctl.table_page, ctl.table_off};
	assign tbl_ok = (tbl_addr <= PA_USER_HI) || ((ctl.table_page & TBLPAGE_CFG_BIT) != 8'h00);

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.denied = 1'b0;
		case (s_ff.st)
			MSM_FE_RESET: nxt_s.st = MSM_FE_CFG0;
			MSM_FE_CFG0:
			begin
				nxt_s.cfg0 = fetch_data;
				nxt_s.st = MSM_FE_CFG1;
			end
			MSM_FE_CFG1:
			begin
				nxt_s.cfg1 = fetch_data;
				nxt_s.pc = PC_RESET;
				nxt_s.st = MSM_FE_RUN;
			end
			MSM_FE_RUN:
			begin
				if (ctl.jump)
					nxt_s.pc = {ctl.target[22:1], 1'b0};
				else if (ctl.step)
					nxt_s.pc = ctl.down ? s_ff.pc - 23'h000002 : s_ff.pc + 23'h000002;
				nxt_s.denied = ctl.table_req & ~tbl_ok;
			end
			default: nxt_s.st = MSM_FE_RESET;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			s_ff.st <= MSM_FE_RESET;
			s_ff.pc <= PC_RESET;
			s_ff.cfg0 <= CFG_RESET;
			s_ff.cfg1 <= CFG_RESET;
			s_ff.denied <= 1'b0;
		end
		else
			s_ff <= nxt_s;
	end

	// Program address is PA_CFG_WORD1 then PA_CFG_WORD2 for the config load, else the counter widened to 24 bits or a table address.
	always_comb
	begin
		prog_addr = {1'b0, s_ff.pc};
		prog_rd = 1'b1;
		case (s_ff.st)
			MSM_FE_RESET: prog_addr = PA_CFG_WORD1;
			MSM_FE_CFG0: prog_addr = PA_CFG_WORD2;
			MSM_FE_CFG1: prog_rd = 1'b0;
			MSM_FE_RUN:
			begin
				if (ctl.table_req)
				begin
					prog_addr = tbl_addr;
					prog_rd = tbl_ok;
				end
			end
			default: prog_rd = 1'b0;
		endcase
	end

	assign table_denied = s_ff.denied;
	assign cfg_word0 = s_ff.cfg0;
	assign cfg_word1 = s_ff.cfg1;
	assign cfg_done = (s_ff.st == MSM_FE_RUN);
	assign in_vector_table = ({1'b0, s_ff.pc} >= PA_IVT_LO) && ({1'b0, s_ff.pc} <= PA_IVT_HI);
	assign in_alt_vector_table = ({1'b0, s_ff.pc} >= PA_AIVT_LO) && ({1'b0, s_ff.pc} <= PA_AIVT_HI);

	AST_PC_EVEN: assert property (@(posedge clock) disable iff (!nrst)
		cfg_done |-> !s_ff.pc[0]) else $error("Program counter left word alignment.");
	AST_START_ZERO: assert property (@(posedge clock) disable iff (!nrst)
		(s_ff.st == MSM_FE_CFG1) |=> (s_ff.pc == PC_RESET) && cfg_done) else $error("Start not zero.");
	AST_STEP_TWO: assert property (@(posedge clock) disable iff (!nrst)
		cfg_done && ctl.step && !ctl.jump && !ctl.down |=> s_ff.pc == $past(s_ff.pc) + 23'h000002)
		else $error("Counter did not step by two.");
	AST_TBL_GATE: assert property (@(posedge clock) disable iff (!nrst)
		cfg_done && ctl.table_req && tbl_addr[23] && !ctl.table_page[7] |=> table_denied)
		else $error("Configuration access not denied.");
endmodule : msm_prog_side

/* File: verilog/msm_wreg.sv */
// Working register array with byte-load, sign-extend, upper-clear and post-increment.
// Assumes at most one update per cycle from the execution stage.
`timescale 1ns/100ps
module msm_wreg
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Update port
	input msm_pkg::msm_wop_t op,
	input wire logic [3:0] sel,
	input wire logic byte_op,
	input wire logic [15:0] din,
	// Read port
	input wire logic [3:0] rsel,
	output logic [15:0] rdata
);
	import msm_pkg::*;

	typedef struct packed
	{
		logic [15:0][15:0] w;
	} msm_wstate_t;

	msm_wstate_t s_ff;
	msm_wstate_t nxt_s;
	logic [15:0] cur;

	assign cur = s_ff.w[sel];

	always_comb
	begin
		nxt_s = s_ff;
		case (op)
			MSM_OP_NONE: nxt_s = s_ff;
			MSM_OP_LOAD: nxt_s.w[sel] = byte_op ? {cur[15:8], din[7:0]} : din;
			MSM_OP_SIGN: nxt_s.w[sel] = {{8{cur[7]}}, cur[7:0]};
			MSM_OP_CLEAR_HI: nxt_s.w[sel] = {8'h00, cur[7:0]};
			MSM_OP_INC: nxt_s.w[sel] = cur + (byte_op ? 16'h0001 : 16'h0002);
			default: nxt_s = s_ff;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign rdata = s_ff.w[rsel];

	AST_BYTE_KEEP: assert property (@(posedge clock) disable iff (!nrst)
		op == MSM_OP_LOAD && byte_op |=> s_ff.w[$past(sel)][15:8] == $past(cur[15:8]))
		else $error("Byte load altered high byte.");
	AST_INC_SIZE: assert property (@(posedge clock) disable iff (!nrst)
		op == MSM_OP_INC && byte_op |=> s_ff.w[$past(sel)] == $past(cur) + 16'h0001)
		else $error("Byte post-increment wrong.");
endmodule : msm_wreg

/* File: tb/msm_prog_mem_model.sv */
// Behavioural program memory that stands in for the core's fetch path.
// Assumes one word is read per cycle and its answer comes one cycle later.
`timescale 1ns/100ps
module msm_prog_mem_model
(
	// Clock
	input wire logic clock,
	// Fetch request
	input wire logic [23:0] prog_addr,
	input wire logic prog_rd,
	// Answer
	output logic [15:0] fetch_data = 16'h0000
);
	// Contents follow the address so the bench can predict them.
	// An idle bus toggles so a stale word is never mistaken for an answer.
	always_ff @(posedge clock)
	begin
		if (prog_rd)
			fetch_data <= prog_addr[15:0] ^ 16'h3C3C;
		else
			fetch_data <= ~fetch_data;
	end
endmodule : msm_prog_mem_model

/* File: tb/msm_data_side_tb.sv */
// Self-checking bench for the memory space access map.
// Assumes the program memory model answers fetches one cycle late.
`timescale 1ns/100ps
module msm_data_side_tb;
	import msm_pkg::*;
	logic clock, nrst, use_near, use_full, wbyte, addr_error_trap, prog_rd;
	logic table_denied, cfg_done, in_vector_table, in_alt_vector_table;
	logic [15:0] fetch_data, full_field, special_rdata, wrdata, window_addr;
	logic [15:0] cfg_word0, cfg_word1;
	logic [12:0] near_field;
	logic [1023:0] special_impl;
	logic [3:0] wsel, wrsel;
	logic [1:0] lane_we;
	logic [23:0] prog_addr;
	msm_pctl_t pctl;
	msm_dreq_t rd_req, wr_req;
	msm_drsp_t rd_rsp;
	msm_wop_t wop;
	int failures, num_checks;

	msm_data_side uut (.clock, .nrst, .pctl, .fetch_data, .use_near, .near_field,
		.use_full, .full_field, .rd_req, .wr_req, .special_rdata, .special_impl,
		.wop, .wsel, .wbyte, .wrsel, .wrdata, .rd_rsp, .window_addr,
		.addr_error_trap, .lane_we, .prog_addr, .prog_rd, .table_denied,
		.cfg_word0, .cfg_word1, .cfg_done, .in_vector_table, .in_alt_vector_table);
	msm_prog_mem_model pmem (.clock, .prog_addr, .prog_rd, .fetch_data);

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic results();
		$display("checks=%0d mismatches=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Data of a misaligned word read is not defined, so it is not compared; valid, window and trap still are.
	task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] exp,
		input logic trap);
		rd_req = '{valid: 1'b1, word: w, addr: a, data: 16'h0000};
		@(negedge clock);
		rd_req.valid = 1'b0;
		check(rd_rsp.valid, 1'b1);
		check(rd_rsp.window, a[15]);
		check(addr_error_trap, trap);
		if (!(w && a[0]))
			check(rd_rsp.data, exp);
	endtask : rd

	task automatic wr(input logic [15:0] a, input logic w, input logic [15:0] d,
		input logic [1:0] lanes, input logic trap);
		wr_req = '{valid: 1'b1, word: w, addr: a, data: d};
		#1 check(lane_we, lanes);
		@(negedge clock);
		wr_req.valid = 1'b0;
		check(addr_error_trap, trap);
	endtask : wr

	task automatic wdo(input msm_wop_t o, input logic b, input logic [15:0] exp);
		wop = o;
		wbyte = b;
		@(negedge clock);
		wop = MSM_OP_NONE;
		check(wrdata, exp);
	endtask : wdo

	task automatic pstep(input logic dn, input logic jp, input logic [22:0] tg,
		input logic [23:0] exp, input logic [1:0] vt);
		pctl.step = ~jp;
		pctl.down = dn;
		pctl.jump = jp;
		pctl.target = tg;
		@(negedge clock);
		pctl.step = 1'b0;
		pctl.jump = 1'b0;
		check(prog_addr, exp);
		check({in_vector_table, in_alt_vector_table}, vt);
	endtask : pstep

	task automatic t_cfg();
		int n = 0;
		while (cfg_done !== 1'b1 && n < 20)
		begin
			@(negedge clock);
			n++;
		end
		if (n == 20)
		begin
			failures++;
			results();
		end
		check(cfg_word0, 16'h97C0);
		check(cfg_word1, 16'h97C2);
		check(prog_addr, 24'h000000);
		$display("test cfg done");
	endtask : t_cfg

	task automatic t_prog();
		pstep(1'b0, 1'b0, 23'h0, 24'h000002, 2'b00);
		pstep(1'b1, 1'b0, 23'h0, 24'h000000, 2'b00);
		pstep(1'b0, 1'b1, 23'h000004, 24'h000004, 2'b10);
		pstep(1'b0, 1'b1, 23'h0000FE, 24'h0000FE, 2'b10);
		pstep(1'b0, 1'b0, 23'h0, 24'h000100, 2'b01);
		pstep(1'b0, 1'b1, 23'h0001FE, 24'h0001FE, 2'b01);
		pstep(1'b0, 1'b0, 23'h0, 24'h000200, 2'b00);
		pstep(1'b0, 1'b1, 23'h7FFFFE, 24'h7FFFFE, 2'b00);
		pctl.table_req = 1'b1;
		pctl.table_page = 8'h80;
		pctl.table_off = 16'hFFFE;
		#1 check(prog_addr, 24'h80FFFE);
		check(prog_rd, 1'b1);
		@(negedge clock);
		pctl.table_req = 1'b0;
		check(table_denied, 1'b0);
		$display("test prog done");
	endtask : t_prog

	task automatic t_rw();
		wr(16'h1000, 1'b1, 16'hBEEF, 2'b11, 1'b0);
		rd(16'h1000, 1'b1, 16'hBEEF, 1'b0);
		rd(16'h1000, 1'b0, 16'h00EF, 1'b0);
		rd(16'h1001, 1'b0, 16'h00BE, 1'b0);
		wr(16'h1001, 1'b0, 16'h0012, 2'b10, 1'b0);
		wr(16'h1000, 1'b0, 16'h0034, 2'b01, 1'b0);
		rd(16'h1000, 1'b1, 16'h1234, 1'b0);
		wr(16'h1FFE, 1'b1, 16'hCAFE, 2'b11, 1'b0);
		rd(16'h1FFF, 1'b0, 16'h00CA, 1'b0);
		$display("test rw done");
	endtask : t_rw

	task automatic t_err();
		wr(16'h1002, 1'b1, 16'h5678, 2'b11, 1'b0);
		wr(16'h1004, 1'b1, 16'h9ABC, 2'b11, 1'b0);
		wr(16'h1003, 1'b1, 16'hDEAD, 2'b00, 1'b1);
		rd(16'h1002, 1'b1, 16'h5678, 1'b0);
		rd(16'h1004, 1'b1, 16'h9ABC, 1'b0);
		rd(16'h1003, 1'b1, 16'h0000, 1'b1);
		wr(16'h07FE, 1'b1, 16'h1111, 2'b00, 1'b0);
		wr(16'h2000, 1'b1, 16'h2222, 2'b00, 1'b0);
		rd(16'h2000, 1'b1, 16'h0000, 1'b0);
		rd(16'h7FFF, 1'b0, 16'h0000, 1'b0);
		rd(16'h8004, 1'b1, 16'h0000, 1'b0);
		check(window_addr, 16'h0004);
		rd(16'hFFFE, 1'b1, 16'h0000, 1'b0);
		check(window_addr, 16'h7FFE);
		$display("test err done");
	endtask : t_err

	task automatic t_special();
		special_impl[16] = 1'b0;
		rd(16'h0020, 1'b1, 16'h0000, 1'b0);
		rd(16'h0022, 1'b1, 16'hA55A, 1'b0);
		rd(16'h0023, 1'b0, 16'h00A5, 1'b0);
		rd(16'h07FE, 1'b1, 16'hA55A, 1'b0);
		$display("test special done");
	endtask : t_special

	task automatic t_direct();
		use_near = 1'b1;
		near_field = 13'h1000;
		rd(16'h2000, 1'b1, 16'h1234, 1'b0);
		near_field = 13'h1FFF;
		rd(16'h2000, 1'b0, 16'h00CA, 1'b0);
		use_near = 1'b0;
		use_full = 1'b1;
		full_field = 16'h1FFE;
		rd(16'h2000, 1'b1, 16'hCAFE, 1'b0);
		use_full = 1'b0;
		$display("test direct done");
	endtask : t_direct

	task automatic t_wreg();
		wr(16'h1100, 1'b1, 16'h80F3, 2'b11, 1'b0);
		rd(16'h1100, 1'b1, 16'h80F3, 1'b0);
		wdo(MSM_OP_LOAD, 1'b0, 16'h80F3);
		rd(16'h1101, 1'b0, 16'h0080, 1'b0);
		wdo(MSM_OP_LOAD, 1'b1, 16'h8080);
		wdo(MSM_OP_SIGN, 1'b0, 16'hFF80);
		wdo(MSM_OP_CLEAR_HI, 1'b0, 16'h0080);
		wdo(MSM_OP_INC, 1'b1, 16'h0081);
		wdo(MSM_OP_INC, 1'b0, 16'h0083);
		$display("test wreg done");
	endtask : t_wreg

	// A second reset in mid-run must reload the configuration words.
	task automatic t_rerst();
		@(negedge clock);
		nrst = 1'b0;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		t_cfg();
		$display("test rerst done");
	endtask : t_rerst

	initial
	begin
		failures = 0;
		num_checks = 0;
		nrst = 1'b0;
		pctl = '0;
		rd_req = '0;
		wr_req = '0;
		use_near = 1'b0;
		use_full = 1'b0;
		near_field = 13'h0000;
		full_field = 16'h0000;
		special_rdata = 16'hA55A;
		special_impl = '1;
		wop = MSM_OP_NONE;
		wsel = 4'h1;
		wrsel = 4'h1;
		wbyte = 1'b0;
		repeat (10) @(negedge clock);
		nrst = 1'b1;
		t_cfg();
		t_prog();
		t_rw();
		t_err();
		t_special();
		t_direct();
		t_wreg();
		t_rerst();
		results();
	end
endmodule : msm_data_side_tb
